// file: include/spsb_params.svh
`ifndef SPSB_PARAMS_SVH
`define SPSB_PARAMS_SVH
// Register byte offsets on the bus.
`define SPSB_OFF_STATUS 8'h00
`define SPSB_OFF_DATA   8'h04
`define SPSB_OFF_CTRL1  8'h08
// Status bit positions.
`define SPSB_BIT_RXF 7
`define SPSB_BIT_TXE 5
`define SPSB_BIT_MF  4
// Control register one bit positions.
`define SPSB_BIT_CS   4
`define SPSB_BIT_FDE  3
`define SPSB_BIT_SOE  2
`define SPSB_BIT_TIE  1
`define SPSB_BIT_RFIE 0
// Reset values.
`define SPSB_RST_CTRL1 5'h00
`define SPSB_RST_BYTE  8'h00
// Controller serial clock half period and the bus clock period.
`define SPSB_SCK_HALF_NS 80
`define SPSB_CLK_NS      20
`define SPSB_SCK_HALF_CYC (`SPSB_SCK_HALF_NS / `SPSB_CLK_NS)
// Index of the last of the sixteen edges in one byte transfer, and the limit for refilling the shifter.
`define SPSB_LAST_EDGE 4'hf
`define SPSB_TXE_CYC   2
`endif

// file: include/spsb_pkg.sv
package spsb_pkg;
	// Fields of control register one.
	typedef struct packed {
		logic cs;   // Controller select.
		logic fde;  // Fault detect enable.
		logic soe;  // Select output enable.
		logic tie;  // Transmit interrupt enable.
		logic rfie; // Receive and fault interrupt enable.
	} spsb_ctrl_s;
	// Captured bus address phase.
	typedef struct packed {
		logic       act;
		logic       wr;
		logic [7:0] addr;
	} spsb_aph_s;
	// Shift engine states.
	typedef enum logic [0:0] {SPSB_IDLE, SPSB_RUN} spsb_st_e;
endpackage

// file: rtl/spsb_top.sv
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "spsb_params.svh"
// Function
// - Transfer end sets receive-full flag.
// - Status read then data read clears receive-full.
// - Transmit-empty shows room in transmit buffer.
// - Status read then data write clears transmit-empty.
// - Data write without prior armed read is dropped.
// - Transmit interrupt when empty and enabled.
// - Buffer-to-shifter move sets transmit-empty.
// - Idle write moves to shifter within two cycles.
// - Shift end loads queued byte into shifter.
// - No queued byte: nothing moves, flag stays.
// - Controller with select low sets mode fault.
// - Fault only when controller, enabled, no output.
// - Status read then control write clears fault.
// - Unused status bits read zero.
// - Status writes are ignored.
// - Data read gives receive, write fills transmit.
// - Controller starts transfer on written byte.
// - Unread receive byte kept, new one dropped.
// - Receive/fault interrupt when flag and enable set.
// - Overrun leaves no status trace.
module spsb_top
	import spsb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	input  wire logic        ss_n_i,
	output logic             tx_irq,
	output logic             rf_irq
);
	// Bus side state.
	spsb_aph_s  aph_ff;     // Address phase held for the data phase.
	spsb_ctrl_s ctrl_ff;    // Control register one.
	logic [7:0] txb_ff;     // Transmit buffer.
	logic       txb_v_ff;   // Transmit buffer holds a byte.
	logic [7:0] rxb_ff;     // Receive buffer.
	logic       rxf_ff;     // Receive-full flag.
	logic       mf_ff;      // Mode-fault flag.
	logic       arm_tx_ff;  // Status seen with transmit-empty set.
	logic       arm_rx_ff;  // Status seen with receive-full set.
	logic       arm_mf_ff;  // Status seen with mode fault set.
	// Shift engine state.
	spsb_st_e   st_ff;      // Controller transfer state.
	logic [7:0] sh_ff;      // Shift register.
	logic       sh_v_ff;    // Shifter holds a byte waiting or in flight.
	logic       smp_ff;     // Bit sampled on the leading edge.
	logic [3:0] ecnt_ff;    // Serial clock edges seen in this byte.
	logic [7:0] hcnt_ff;    // Controller half period counter.
	// Pin synchronisers, two stages, plus a third stage for edges.
	logic [3:0] s1_ff;
	logic [3:0] s2_ff;
	logic       sck_d_ff;

	// Address decode, used once per access kind.
	function automatic logic is_off(input logic [7:0] a, input logic [7:0] o);
		is_off = (a == o);
	endfunction

	wire        aph_take = hsel & htrans[1] & hready;
	wire        rd_take  = aph_take & ~hwrite;
	wire        tx_empty = ~txb_v_ff;
	wire        rd_stat  = rd_take & is_off(haddr[7:0], `SPSB_OFF_STATUS);
	wire        rd_dat   = rd_take & is_off(haddr[7:0], `SPSB_OFF_DATA);
	wire        rd_ctl   = rd_take & is_off(haddr[7:0], `SPSB_OFF_CTRL1);
	wire        wr_ph    = aph_ff.act & aph_ff.wr;
	wire        wr_dat   = wr_ph & is_off(aph_ff.addr, `SPSB_OFF_DATA);
	wire        wr_ctl   = wr_ph & is_off(aph_ff.addr, `SPSB_OFF_CTRL1);
	// A data write lands only after an armed status read.
	wire        tx_load  = wr_dat & arm_tx_ff;
	// Status image; unused bits are constant zero.
	wire [7:0]  stat_img = {rxf_ff, 1'b0, tx_empty, mf_ff, 4'h0};
	wire [31:0] rd_mux   = rd_stat ? {24'h0, stat_img} :
	                       rd_dat  ? {24'h0, rxb_ff} :
	                       rd_ctl  ? {27'h0, ctrl_ff} : 32'h0;
	// Receive-full clears on a data read after an armed status read.
	wire        rx_clr   = rd_dat & arm_rx_ff;
	wire        mf_clr   = wr_ctl & arm_mf_ff;

	// Synchronised pins.
	wire        sck_s    = s2_ff[0];
	wire        mosi_s   = s2_ff[1];
	wire        miso_s   = s2_ff[2];
	wire        ss_n_s   = s2_ff[3];
	// Select pin acts as a fault input only in this configuration.
	wire        flt_en   = ctrl_ff.cs & ctrl_ff.fde & ~ctrl_ff.soe;
	wire        flt_set  = flt_en & ~ss_n_s;
	// Leading and trailing serial clock edges for either role.
	wire        half_end = (hcnt_ff == 8'(`SPSB_SCK_HALF_CYC - 1));
	wire        c_tick   = ctrl_ff.cs & (st_ff == SPSB_RUN) & half_end;
	wire        s_sel    = ~ctrl_ff.cs & ~ss_n_s;
	wire        lead     = ctrl_ff.cs ? (c_tick & ~sck_o) : (s_sel & sck_s & ~sck_d_ff);
	wire        trail    = ctrl_ff.cs ? (c_tick & sck_o) : (s_sel & ~sck_s & sck_d_ff);
	wire        din      = ctrl_ff.cs ? miso_s : mosi_s;
	wire        done     = trail & (ecnt_ff == `SPSB_LAST_EDGE);
	// A waiting byte moves into an empty shifter between transfers.
	wire        sh_load  = txb_v_ff & ~sh_v_ff & (ecnt_ff == 4'h0);
	wire        c_start  = ctrl_ff.cs & sh_v_ff & (st_ff == SPSB_IDLE);

	// Bus answers: always ready, always OKAY, read data registered.
	always_ff @(posedge clk) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0;
			aph_ff    <= '0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (aph_take) begin
				hrdata <= rd_mux;
			end
			if (hready) begin
				aph_ff <= '{act: aph_take, wr: hwrite, addr: haddr[7:0]};
			end
		end
	end

	// Control register one; status writes fall through decode unused.
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= `SPSB_RST_CTRL1;
		end else if (wr_ctl) begin
			ctrl_ff <= hwdata[4:0];
		end
	end

	// Arming by status reads; each arm is spent by its own follow-up.
	always_ff @(posedge clk) begin
		if (rst) begin
			arm_tx_ff <= 1'b0;
			arm_rx_ff <= 1'b0;
			arm_mf_ff <= 1'b0;
		end else if (rd_stat) begin
			// A write or clear landing in this same cycle spends the arm at once.
			// Otherwise a back-to-back status read could arm a second write
			// that overwrites the byte already queued.
			arm_tx_ff <= tx_empty & ~tx_load;
			arm_rx_ff <= rxf_ff;
			arm_mf_ff <= mf_ff & ~mf_clr;
		end else begin
			if (wr_dat) begin
				arm_tx_ff <= 1'b0;
			end
			if (rd_dat) begin
				arm_rx_ff <= 1'b0;
			end
			if (wr_ctl) begin
				arm_mf_ff <= 1'b0;
			end
		end
	end

	// Transmit buffer: filled by an accepted write, emptied by the move.
	always_ff @(posedge clk) begin
		if (rst) begin
			txb_ff   <= `SPSB_RST_BYTE;
			txb_v_ff <= 1'b0;
		end else if (tx_load) begin
			txb_ff   <= hwdata[7:0];
			txb_v_ff <= 1'b1;
		end else if (sh_load) begin
			txb_v_ff <= 1'b0;
		end
	end

	// Receive buffer; an unread byte is kept and the new one dropped.
	always_ff @(posedge clk) begin
		if (rst) begin
			rxb_ff <= `SPSB_RST_BYTE;
			rxf_ff <= 1'b0;
		end else if (done & (~rxf_ff | rx_clr)) begin
			rxb_ff <= {sh_ff[6:0], smp_ff};
			rxf_ff <= 1'b1;
		end else if (rx_clr) begin
			rxf_ff <= 1'b0;
		end
		// An overrun changes nothing here and sets no flag.
	end

	// Mode fault flag; a fault in the clearing cycle keeps it set.
	always_ff @(posedge clk) begin
		if (rst) begin
			mf_ff <= 1'b0;
		end else if (flt_set) begin
			mf_ff <= 1'b1;
		end else if (mf_clr) begin
			mf_ff <= 1'b0;
		end
	end

	// Interrupt requests, registered.
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_irq <= 1'b0;
			rf_irq <= 1'b0;
		end else begin
			tx_irq <= tx_empty & ctrl_ff.tie;
			rf_irq <= (rxf_ff | mf_ff) & ctrl_ff.rfie;
		end
	end

	// Two flip-flop synchronisers for every link pin.
	always_ff @(posedge clk) begin
		if (rst) begin
			// Idle pin levels: select high, clock and data low, so no false edge.
			s1_ff    <= 4'h8;
			s2_ff    <= 4'h8;
			sck_d_ff <= 1'b0;
		end else begin
			s1_ff    <= {ss_n_i, miso_i, mosi_i, sck_i};
			s2_ff    <= s1_ff;
			sck_d_ff <= s2_ff[0];
		end
	end

	// Controller state and serial clock generation.
	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff   <= SPSB_IDLE;
			hcnt_ff <= 8'h0;
			sck_o   <= 1'b0;
		end else begin
			case (st_ff)
				SPSB_IDLE: begin
					hcnt_ff <= 8'h0;
					sck_o   <= 1'b0;
					if (c_start) begin
						st_ff <= SPSB_RUN;
					end
				end
				SPSB_RUN: begin
					hcnt_ff <= half_end ? 8'h0 : hcnt_ff + 8'h1;
					if (half_end) begin
						sck_o <= ~sck_o;
					end
					if (done | ~ctrl_ff.cs) begin
						st_ff <= SPSB_IDLE;
					end
				end
				default: begin
					st_ff <= SPSB_IDLE;
				end
			endcase
		end
	end

	// Shift register: load, sample on leading, shift on trailing edge.
	always_ff @(posedge clk) begin
		if (rst) begin
			sh_ff   <= `SPSB_RST_BYTE;
			sh_v_ff <= 1'b0;
			smp_ff  <= 1'b0;
			ecnt_ff <= 4'h0;
		end else begin
			if (sh_load) begin
				sh_ff   <= txb_ff;
				sh_v_ff <= 1'b1;
			end else if (trail) begin
				sh_ff <= {sh_ff[6:0], smp_ff};
			end
			if (lead) begin
				smp_ff <= din;
			end
			if (done) begin
				sh_v_ff <= 1'b0;
				ecnt_ff <= 4'h0;
			end else if (lead | trail) begin
				ecnt_ff <= ecnt_ff + 4'h1;
			end else if (~ctrl_ff.cs & ss_n_s) begin
				ecnt_ff <= 4'h0;
			end
		end
	end

	// Pin drives: controller owns clock and data out, target owns data in.
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_oe  <= 1'b0;
			mosi_o  <= 1'b0;
			mosi_oe <= 1'b0;
			miso_o  <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			sck_oe  <= ctrl_ff.cs;
			mosi_o  <= sh_ff[7];
			mosi_oe <= ctrl_ff.cs;
			miso_o  <= sh_ff[7];
			miso_oe <= s_sel;
		end
	end

	// Checks on the flag and buffer behaviour.
	property p_rx_set;
		@(posedge clk) disable iff (rst) done & ~rxf_ff |=> rxf_ff;
	endproperty
	a_rx_set: assert property (p_rx_set) else $error("receive-full not set");

	property p_rx_keep;
		@(posedge clk) disable iff (rst) done & rxf_ff & ~rx_clr |=> $stable(rxb_ff) & rxf_ff;
	endproperty
	a_rx_keep: assert property (p_rx_keep) else $error("overrun changed buffer");

	property p_rx_clr;
		@(posedge clk) disable iff (rst) rxf_ff & ~arm_rx_ff & ~rd_stat |=> rxf_ff;
	endproperty
	a_rx_clr: assert property (p_rx_clr) else $error("receive-full lost unarmed");

	property p_wr_drop;
		@(posedge clk) disable iff (rst) wr_dat & ~arm_tx_ff & ~txb_v_ff |=> ~txb_v_ff;
	endproperty
	a_wr_drop: assert property (p_wr_drop) else $error("unarmed write taken");

	property p_idle_move;
		@(posedge clk) disable iff (rst)
			tx_load & ~sh_v_ff & (st_ff == SPSB_IDLE) & (ecnt_ff == 4'h0) |=> ##[1:2] tx_empty;
	endproperty
	a_idle_move: assert property (p_idle_move) else $error("idle byte not moved");

	property p_no_fault;
		@(posedge clk) disable iff (rst) ~flt_en & ~mf_ff |=> ~mf_ff;
	endproperty
	a_no_fault: assert property (p_no_fault) else $error("fault set while disabled");

	property p_tx_irq;
		@(posedge clk) disable iff (rst) tx_empty & ctrl_ff.tie |=> tx_irq;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("transmit request missing");

	property p_rf_irq;
		@(posedge clk) disable iff (rst) (rxf_ff | mf_ff) & ctrl_ff.rfie |=> rf_irq;
	endproperty
	a_rf_irq: assert property (p_rf_irq) else $error("receive request missing");

	property p_zero_bits;
		@(posedge clk) disable iff (rst) rd_stat |=> (hrdata[6] == 1'b0) && (hrdata[3:0] == 4'h0);
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("unused status bit set");

	property p_start;
		@(posedge clk) disable iff (rst) c_start |=> st_ff == SPSB_RUN;
	endproperty
	a_start: assert property (p_start) else $error("controller did not start");

	property p_mf_set;
		@(posedge clk) disable iff (rst) flt_set |=> mf_ff;
	endproperty
	a_mf_set: assert property (p_mf_set) else $error("mode fault not set");

	property p_sh_reload;
		@(posedge clk) disable iff (rst) done & txb_v_ff |=> ##1 (sh_v_ff & tx_empty);
	endproperty
	a_sh_reload: assert property (p_sh_reload) else $error("queued byte not moved");

	property p_no_reload;
		@(posedge clk) disable iff (rst) done & ~txb_v_ff & ~tx_load |=> ~sh_v_ff & tx_empty;
	endproperty
	a_no_reload: assert property (p_no_reload) else $error("shifter loaded from empty");
endmodule

// file: bench/spsb_peer.sv
`timescale 1ns/100ps
// Far-side serial device: a target that answers the block, or a controller that drives it.
module spsb_peer (
	input  wire logic       rst,
	input  wire logic       sck_o,
	input  wire logic       mosi_o,
	input  wire logic [7:0] reply,
	output logic            miso_i,
	output logic            sck_i,
	output logic            mosi_i,
	output logic            ss_n_i,
	output logic [7:0]      heard
);
	logic [2:0] k; // Falling clock edges seen in the current frame.
	initial begin
		k = 3'h0;
		heard = 8'h00;
		sck_i = 1'b0;
		mosi_i = 1'b0;
		ss_n_i = 1'b1;
	end
	// The answer goes out MSB first; a bit stands until the next falling edge.
	assign miso_i = reply[3'h7 - k];
	// The controller's data is sampled on the rising edge.
	always @(posedge sck_o) begin
		heard <= {heard[6:0], mosi_o};
	end
	// The next bit is put out on the falling edge; reset hides the first settle.
	always @(negedge sck_o) begin
		if (!rst) begin
			k <= k + 3'h1;
		end
	end
	// Controller role: one clock-idle-low frame; the clock stands still outside it.
	task automatic send(input logic [7:0] b);
		ss_n_i = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi_i = b[i];
			#80;
			sck_i = 1'b1;
			#80;
			sck_i = 1'b0;
		end
		#80;
		mosi_i = ~mosi_i;
		ss_n_i = 1'b1;
		#160;
	endtask
	// Drives the select line to a level.
	task automatic hold(input logic v);
		ss_n_i <= v;
	endtask
endmodule

// file: bench/spsb_top_test.sv
`timescale 1ns/100ps
`include "spsb_params.svh"
`define CHK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp); \
	end \
end
module spsb_top_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0]  reply = 8'h5a;
	logic [7:0]  heard;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, sck_o, mosi_o, sck_i, mosi_i, miso_i, ss_n_i;
	logic        tx_irq, rf_irq;
	logic        sck_oe, mosi_oe, miso_oe;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	// The one slave's ready is the bus ready.
	spsb_top i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sck_i(sck_i),
		.sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
		.miso_i(miso_i), .miso_o(), .miso_oe(miso_oe), .ss_n_i(ss_n_i), .tx_irq(tx_irq),
		.rf_irq(rf_irq));
	spsb_peer i_peer (.rst(rst), .sck_o(sck_o), .mosi_o(mosi_o), .reply(reply),
		.miso_i(miso_i), .sck_i(sck_i), .mosi_i(mosi_i), .ss_n_i(ss_n_i), .heard(heard));
	always #10 clk = ~clk;
	// Cuts a hung run short.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	// One single word transfer; the master waits for ready in each phase.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	// Polls the status until a byte has arrived, under a bound.
	task automatic wait_rx(output logic [31:0] q);
		int n;
		n = 0;
		do begin
			rd(`SPSB_OFF_STATUS, q);
			n++;
		end while (q[7] !== 1'b1 && n < 300);
	endtask
	// A data write with no status read before it must start nothing.
	task automatic t_drop;
		logic [31:0] q;
		wr(`SPSB_OFF_CTRL1, 32'h10);
		wr(`SPSB_OFF_DATA, 32'ha5);
		repeat (100) @(posedge clk);
		rd(`SPSB_OFF_STATUS, q);
		`CHK(q, 32'h20)
		$display("test drop done");
	endtask
	// Status layout, ignored status writes and an unmapped address.
	task automatic t_idle;
		logic [31:0] q;
		`CHK(hresp, 1'b0)
		wr(`SPSB_OFF_STATUS, 32'hff);
		rd(`SPSB_OFF_STATUS, q);
		`CHK(q, 32'h20)
		rd(8'h0c, q);
		`CHK(q, 32'h0)
		$display("test idle done");
	endtask
	// Two queued bytes as controller, then the buffer drains empty.
	task automatic t_ctrl;
		logic [31:0] q;
		wr(`SPSB_OFF_CTRL1, 32'h13);
		repeat (3) @(posedge clk);
		`CHK(tx_irq, 1'b1)
		`CHK(sck_oe, 1'b1)
		`CHK(mosi_oe, 1'b1)
		rd(`SPSB_OFF_STATUS, q);
		wr(`SPSB_OFF_DATA, 32'h3c);
		repeat (3) @(posedge clk);
		rd(`SPSB_OFF_STATUS, q);
		`CHK(q, 32'h20)
		wr(`SPSB_OFF_DATA, 32'hc3);
		repeat (2) @(posedge clk);
		rd(`SPSB_OFF_STATUS, q);
		`CHK(q, 32'h00)
		`CHK(tx_irq, 1'b0)
		wait_rx(q);
		`CHK(q, 32'ha0)
		`CHK(rf_irq, 1'b1)
		rd(`SPSB_OFF_DATA, q);
		`CHK(q, 32'h5a)
		wait_rx(q);
		rd(`SPSB_OFF_DATA, q);
		rd(`SPSB_OFF_STATUS, q);
		`CHK(q, 32'h20)
		`CHK(heard, 8'hc3)
		$display("test controller done");
	endtask
	// Two frames as target with no read between them: the second is lost.
	task automatic t_rx;
		logic [31:0] q;
		wr(`SPSB_OFF_CTRL1, 32'h00);
		i_peer.send(8'h11);
		i_peer.send(8'h22);
		repeat (4) @(posedge clk);
		`CHK(tx_irq, 1'b0)
		rd(`SPSB_OFF_DATA, q);
		rd(`SPSB_OFF_STATUS, q);
		`CHK(q, 32'ha0)
		rd(`SPSB_OFF_DATA, q);
		`CHK(q, 32'h11)
		rd(`SPSB_OFF_STATUS, q);
		`CHK(q, 32'h20)
		$display("test target done");
	endtask
	// Select driven low under each setting, then the clear sequence.
	task automatic t_fault;
		logic [31:0] q;
		logic [7:0]  cfg [4] = '{8'h18, 8'h19, 8'h1c, 8'h08};
		logic [31:0] st [4] = '{32'h30, 32'h30, 32'h20, 32'h20};
		for (int i = 0; i < 4; i++) begin
			wr(`SPSB_OFF_CTRL1, {24'h0, cfg[i]});
			i_peer.hold(1'b0);
			repeat (8) @(posedge clk);
			`CHK(rf_irq, cfg[i][0] & st[i][4])
			`CHK(miso_oe, ~cfg[i][4])
			i_peer.hold(1'b1);
			repeat (4) @(posedge clk);
			rd(`SPSB_OFF_STATUS, q);
			`CHK(q, st[i])
			wr(`SPSB_OFF_CTRL1, 32'h0);
			rd(`SPSB_OFF_STATUS, q);
			`CHK(q, 32'h20)
		end
		$display("test fault done");
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_drop();
		t_idle();
		t_ctrl();
		t_rx();
		t_fault();
		close_out();
	end
endmodule
